// ==== design/sdm_codec_map.vh ====
`ifndef SDM_CODEC_MAP_VH
`define SDM_CODEC_MAP_VH
// =====================================
// clocking
`define CLK_PERIOD_NS 8
`define MOD_RATE_KHZ 6000
`define REF_RATE_KHZ 125000
// modulator sample divider, 125 MHz / 6 MHz rounded down
`define MOD_DIV (`REF_RATE_KHZ / `MOD_RATE_KHZ)
// =====================================
// modulator widths and levels
`define SAMPLE_W 16
`define ACC_W 24
`define FULL_SCALE 24'h007FFF
// =====================================
// encoder pulse widths in ref_clk cycles
`define PULSE_SHORT 2
`define PULSE_LONG 5
// every Nth pulse is stretched
`define STRETCH_EVERY 4
// =====================================
// decoder time-out in ref_clk cycles
`define TIMEOUT_CYC 200
`define CNT_W 8
// =====================================
// fifo
`define FIFO_W 16
`define FIFO_D 16
`define FIFO_AW 4
`endif

// ==== design/sigma_delta_edge_codec.v ====
// Operation
// - modulator sampled at about 6 MHz; bitstream average tracks input
// - second order: two integrators and a comparator once per sample
// - encoder emits one pulse per bitstream transition, both directions
// - every fourth encoder pulse is stretched; the decoder only uses rising edges, not pulse width
// - decoder toggles recovered data on each encoded rising edge
// - decoder is two toggle flip-flops with two time-out circuits
// - the two flip-flops run in opposite phase, giving a complementary pair
// - recovered pair goes straight to the dac outputs
`timescale 1ns/10ps
`default_nettype none
`include "sdm_codec_map.vh"

// =====================================
// sample fifo
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // write side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // read side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_r;
  reg [AW:0] rdPtr_r;
  wire full;
  wire empty;
  assign empty = (wrPtr_r == rdPtr_r);
  assign full = (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]) && (wrPtr_r[AW] != rdPtr_r[AW]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_r[AW-1:0]];
  always @(posedge ref_clk)
  begin
    if (inValid && !full)
      mem[wrPtr_r[AW-1:0]] <= inData;
  end
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wrPtr_r <= {(AW+1){1'b0}};
      rdPtr_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (inValid && !full)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (outReady && !empty)
        rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
endmodule

// =====================================
// top
module sigma_delta_edge_codec (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // input samples, signed
  input wire sampleValid,
  output wire sampleReady,
  input wire [`SAMPLE_W-1:0] sampleData,
  // modulator bitstream and optical drive
  output reg modBit,
  output reg ledDrive,
  // optical receive pin, asynchronous
  input wire detIn,
  // recovered differential data to dac
  output reg dacPos,
  output reg dacNeg
);
  // =====================================
  // sample pacing and fifo
  // integer constants are cut on purpose where they meet narrow counters
  localparam integer DIV_LAST = `MOD_DIV - 1;
  localparam integer LONG_LAST = `PULSE_LONG - 1;
  localparam integer SHORT_LAST = `PULSE_SHORT - 1;
  reg [7:0] div_r;
  wire tick;
  wire fifoValid;
  wire [`FIFO_W-1:0] fifoData;
  reg [`SAMPLE_W-1:0] held_r;
  assign tick = (div_r == DIV_LAST[7:0]);
  always @(posedge ref_clk)
  begin
    if (rst)
      div_r <= 8'h00;
    else if (tick)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end
  // fifo drains one sample per modulator tick, so a fast source is held back
  sample_fifo #(.WIDTH(`FIFO_W), .DEPTH(`FIFO_D), .AW(`FIFO_AW)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inData(sampleData),
    .outValid(fifoValid),
    .outReady(tick),
    .outData(fifoData)
  );
  // last sample is reused when the fifo runs dry
  always @(posedge ref_clk)
  begin
    if (rst)
      held_r <= 16'h0000;
    else if (tick && fifoValid)
      held_r <= fifoData;
  end

  // =====================================
  // second-order modulator
  reg signed [`ACC_W-1:0] int1_r;
  reg signed [`ACC_W-1:0] int2_r;
  wire signed [`ACC_W-1:0] xIn;
  wire signed [`ACC_W-1:0] fb;
  wire signed [`ACC_W-1:0] int1Nxt;
  wire signed [`ACC_W-1:0] int2Nxt;
  assign xIn = {{(`ACC_W-`SAMPLE_W){held_r[`SAMPLE_W-1]}}, held_r};
  assign fb = modBit ? `FULL_SCALE : -`FULL_SCALE;
  assign int1Nxt = int1_r + xIn - fb;
  assign int2Nxt = int2_r + int1Nxt - fb;
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      int1_r <= 24'h000000;
      int2_r <= 24'h000000;
      modBit <= 1'b0;
    end
    else if (tick)
    begin
      int1_r <= int1Nxt;
      int2_r <= int2Nxt;
      modBit <= !int2Nxt[`ACC_W-1];
    end
  end

  // =====================================
  // edge encoder
  reg prevBit_r;
  reg [2:0] pulseCnt_r;
  reg [1:0] edgeCnt_r;
  wire edgeSeen;
  assign edgeSeen = modBit ^ prevBit_r;
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      prevBit_r <= 1'b0;
      pulseCnt_r <= 3'h0;
      edgeCnt_r <= 2'h0;
      ledDrive <= 1'b0;
    end
    else
    begin
      prevBit_r <= modBit;
      // pulses fit well inside one sample period, so they never overlap
      if (edgeSeen)
      begin
        edgeCnt_r <= edgeCnt_r + 2'h1;
        ledDrive <= 1'b1;
        if (edgeCnt_r == `STRETCH_EVERY - 1)
          pulseCnt_r <= LONG_LAST[2:0];
        else
          pulseCnt_r <= SHORT_LAST[2:0];
      end
      else if (pulseCnt_r != 3'h0)
        pulseCnt_r <= pulseCnt_r - 3'h1;
      else
        ledDrive <= 1'b0;
    end
  end

  // =====================================
  // decoder
  reg det1_r;
  reg det2_r;
  reg det3_r;
  reg [`CNT_W-1:0] toP_r;
  reg [`CNT_W-1:0] toN_r;
  wire rise;
  // det1_r is only read by det2_r
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      det1_r <= 1'b0;
      det2_r <= 1'b0;
      det3_r <= 1'b0;
    end
    else
    begin
      det1_r <= detIn;
      det2_r <= det1_r;
      det3_r <= det2_r;
    end
  end
  assign rise = det2_r && !det3_r;
  // one time-out per flip-flop; an idle stream means the bit stopped low
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      dacPos <= 1'b0;
      dacNeg <= 1'b1;
      toP_r <= 8'h00;
      toN_r <= 8'h00;
    end
    else if (rise)
    begin
      dacPos <= !dacPos;
      dacNeg <= !dacNeg;
      toP_r <= 8'h00;
      toN_r <= 8'h00;
    end
    else
    begin
      if (toP_r == `TIMEOUT_CYC - 1)
        dacPos <= 1'b0;
      else
        toP_r <= toP_r + 8'h01;
      if (toN_r == `TIMEOUT_CYC - 1)
        dacNeg <= 1'b1;
      else
        toN_r <= toN_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== verif/opto_link.sv ====
`timescale 1ns/10ps
`default_nettype none
module opto_link (
  input wire logic ref_clk,
  input wire logic ledDrive,
  input wire logic slow,
  input wire logic dark,
  output logic detIn
);
  logic [3:0] pipe_r = 4'h0;
  always @(posedge ref_clk)
    pipe_r <= {pipe_r[2:0], ledDrive};
  // a dark link carries no light, so the detector reads low
  assign detIn = !dark && (slow ? pipe_r[3] : pipe_r[0]);
endmodule
`default_nettype wire

// ==== verif/codec_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module codec_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic modBit,
  input wire logic ledDrive,
  input wire logic detIn,
  input wire logic dacPos,
  input wire logic dacNeg
);
  logic [1:0] pc_r;
  logic [7:0] idle_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // idle count saturates so a long gap never wraps
  always @(posedge ref_clk)
  begin
    pc_r <= rst ? 2'h0 : pc_r + {1'b0, $rose(ledDrive)};
    idle_r <= rst || $rose(detIn) ? 8'h00 : idle_r + {7'h00, ~&idle_r};
  end
  chk_pulse_on: assert property ($changed(modBit) |=> $rose(ledDrive)) else $error("pulse");
  chk_no_stray: assert property ($rose(ledDrive) |-> $past(modBit) != $past(modBit, 2))
    else $error("stray");
  chk_short_len: assert property ($rose(ledDrive) && pc_r != 2'h3 |-> ledDrive[*2] ##1 !ledDrive)
    else $error("short");
  chk_long_len: assert property ($rose(ledDrive) && pc_r == 2'h3 |-> ledDrive[*5] ##1 !ledDrive)
    else $error("long");
  chk_bit_rate: assert property ($changed(modBit) |=> $stable(modBit)[*8]) else $error("rate");
  chk_dac_flip: assert property ($rose(detIn) |-> ##[2:4] $changed(dacPos)) else $error("flip");
  chk_dac_pair: assert property (dacNeg != dacPos) else $error("pair");
  chk_dac_idle: assert property (idle_r == 8'hF0 |-> !dacPos && dacNeg) else $error("idle");
  cover property ($rose(ledDrive) && pc_r == 2'h3);
  cover property (idle_r == 8'hF0);
  cover property ($rose(dacPos));
endmodule
bind sigma_delta_edge_codec codec_sva u_codec_sva (
  .ref_clk(ref_clk),
  .rst(rst),
  .modBit(modBit),
  .ledDrive(ledDrive),
  .detIn(detIn),
  .dacPos(dacPos),
  .dacNeg(dacNeg)
);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0, rst = 1'b1, sampleValid = 1'b0, slow = 1'b0, dark = 1'b0;
  logic [15:0] sampleData = 16'h0000;
  logic [31:0] r;
  logic expQ[$];
  logic expBit;
  int error_cnt = 0, comparisons = 0;
  wire logic sampleReady, modBit, ledDrive, detIn, dacPos, dacNeg;
  always #4 ref_clk = ~ref_clk;
  sigma_delta_edge_codec u_sigma_delta_edge_codec (.*);
  opto_link u_opto_link (.*);
  task automatic cmp(input logic got, exp);
    comparisons++;
    error_cnt += int'(got !== exp);
    if (got !== exp)
      $display("ERROR %0t mismatch", $time);
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // no note while dark: no light reaches the decoder
  always @(posedge ledDrive)
    if (!dark)
      expQ.push_back(modBit);
  // both outputs settle in one update; look a little later so neither is stale
  always @(dacPos)
    if (!rst && !dark && expQ.size() > 0)
    begin
      expBit = expQ.pop_front();
      #1;
      cmp(dacPos, expBit);
      cmp(dacNeg, !expBit);
    end
  task automatic offer(input int n, input logic [1:0] m);
    repeat (n)
    begin
      @(negedge ref_clk);
      r = $urandom;
      sampleValid = m[1] | m[0] & r[12];
      sampleData = {{5{r[10]}}, r[10:0]};
    end
  endtask
  initial
  begin
    r = $urandom(32'h274F);
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    offer(900, 2'h1);
    offer(18, 2'h2);
    cmp(sampleReady, 1'b0);
    offer(400, 2'h0);
    cmp(sampleReady, 1'b1);
    @(posedge dacPos);
    @(negedge ref_clk) dark = 1'b1;
    slow = 1'b1;
    offer(260, 2'h1);
    cmp(dacPos, 1'b0);
    @(posedge modBit);
    @(negedge ref_clk) dark = 1'b0;
    offer(200, 2'h1);
    // a dead decoder leaves notes piling up
    cmp(expQ.size() < 2, 1'b1);
    finish_test;
  end
  initial
  begin
    #160000 error_cnt++;
    finish_test;
  end
endmodule
`default_nettype wire
